// >>> scc_pkg.sv
// constants of the clock-control and sysref register bank
// assumes an 8-bit register port and byte-wide registers at printed offsets
package scc_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int POS_W = 24;
    localparam int SEL_W = 4;
    localparam int SAMPLE_W = 12;
    localparam int DECIM_W = 6;
    localparam int FS_W = 16;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [14:0] OFS_CLOCK_CONTROL_ZERO = 15'h0029;
    localparam logic [14:0] OFS_CLOCK_CONTROL_ONE = 15'h002a;
    localparam logic [14:0] OFS_CLOCK_CONTROL_TWO = 15'h002b;
    localparam logic [14:0] OFS_SREF_POS_LO = 15'h002c;
    localparam logic [14:0] OFS_SREF_POS_MID = 15'h002d;
    localparam logic [14:0] OFS_SREF_POS_HI = 15'h002e;
    localparam logic [14:0] OFS_FULL_SCALE_A_LO = 15'h0030;
    localparam logic [14:0] OFS_FULL_SCALE_A_HI = 15'h0031;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_CLOCK_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] RST_CLOCK_CONTROL_ONE = 8'h00;
    localparam logic [7:0] RST_CLOCK_CONTROL_TWO = 8'h11;
    localparam logic [23:0] RST_SREF_POS = 24'h000000;
    localparam logic [15:0] RST_FULL_SCALE_A = 16'ha000;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BIT_PROC_EN = 6;
    localparam int BIT_RECV_EN = 5;
    localparam int BIT_FINE_STEPS = 4;
    localparam int SEL_LSB = 0;
    localparam int BIT_TIMESTAMP = 3;
    localparam int BIT_DEVCLK_PECL = 2;
    localparam int BIT_SREF_PECL = 1;
    localparam int BIT_INVERT = 0;
    localparam int BIT_FB_GAIN = 4;
    localparam int BIT_NOISE_SUPP = 2;
    localparam int DEL_LSB = 0;
    localparam int DEL_W = 2;

    localparam logic [5:0] DECIM_BYPASS = 6'h01;

    // register selected by an access
    typedef enum {
        SEL_NONE,
        SEL_CTRL0,
        SEL_CTRL1,
        SEL_CTRL2,
        SEL_POS0,
        SEL_POS1,
        SEL_POS2,
        SEL_FS0,
        SEL_FS1
    } scc_reg_t;

endpackage

// >>> scc_sync.sv
// two-flop synchroniser for one level from outside the core clock domain
// assumes the level is held for at least two core clock periods
`timescale 1ns/1ps
module scc_sync (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// >>> scc_pos_detect.sv
// sysref window history, delay tap selection and edge position capture
// assumes sref_level is already synchronised, gated and polarity corrected
`timescale 1ns/1ps
module scc_pos_detect (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sref_level,
    input wire logic proc_en,
    input wire logic fine_steps,
    input wire logic [3:0] delay_sel,
    output logic [23:0] position,
    output logic aligned,
    output logic sref_event
);

    logic [23:0] history_ff;
    logic [23:0] position_ff;
    logic half_ff;
    logic level_prev_ff;
    logic aligned_ff;
    logic aligned_prev_ff;
    logic event_ff;
    logic step;

    // coarse steps advance the window every other cycle
    assign step = fine_steps | half_ff; // R4

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_ff <= 1'b0;
        end else begin
            half_ff <= ~half_ff;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            history_ff <= '0;
        end else if (step) begin
            history_ff <= {history_ff[22:0], sref_level};
        end
    end

    // capture the window on each raw rising edge while processing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_prev_ff <= 1'b0;
            position_ff <= scc_pkg::RST_SREF_POS;
        end else begin
            level_prev_ff <= sref_level;
            if (proc_en && sref_level && !level_prev_ff) begin
                position_ff <= history_ff; // R17
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aligned_ff <= 1'b0;
            aligned_prev_ff <= 1'b0;
            event_ff <= 1'b0;
        end else begin
            aligned_ff <= history_ff[delay_sel]; // R6
            aligned_prev_ff <= aligned_ff;
            event_ff <= proc_en & aligned_ff & ~aligned_prev_ff; // R1
        end
    end

    assign position = position_ff;
    assign aligned = aligned_ff;
    assign sref_event = event_ff;

endmodule

// >>> scc_regs.sv
// clock-control and sysref register bank with its sysref datapath
// assumes the serial port front end delivers one-cycle byte read and write strobes
`timescale 1ns/1ps

// How it works
// R1: processor enable bit gates all sysref events; cleared at reset.
// R2: host enables the receiver before the processor, never processor alone.
// R3: receiver enable bit turns the sysref input receiver on.
// R4: fine-step bit shrinks window delay steps for status and delay select.
// R5: host uses fine steps at high clock rates or multiple windows.
// R6: four-bit delay select chooses the applied sysref capture delay.
// R7: host writes zero to delay select before automatic calibration.
// R8: timestamp bit plus sample timestamp enable put sysref on sample lsb.
// R9: sysref timestamp works only with decimation factor one.
// R10: device clock receiver dc-coupled pecl mode bit.
// R11: sysref receiver dc-coupled pecl mode bit.
// R12: invert bit flips sysref polarity used for alignment.
// R13: feedback gain bit of clock converter, resets to high gain.
// R14: noise suppression bit for the analog 1.1 V supply.
// R15: two-bit one-hot sampling clock delay, resets to one.
// R16: third control register resets to 0x11.
// R17: position register reports 24-bit sysref edge position.
// R18: host picks delay select from the read-back position word.
// R19: first and second control registers reset to zero.
// R20: host waits 750 ns after soft reset before port access.
// R21: writes to the position register leave it unchanged.
module scc_regs (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [14:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic sref_pin,
    input wire logic sample_timestamp_enable,
    input wire logic [5:0] decimation_factor,
    input wire logic [11:0] sample_in,
    input wire logic sample_in_valid,
    output logic [11:0] sample_out,
    output logic sample_out_valid,
    output logic sref_event,
    output logic sref_receiver_on,
    output logic devclock_dc_pecl_enable,
    output logic sref_dc_pecl_enable,
    output logic clock_feedback_high_gain,
    output logic analog_supply_noise_suppress,
    output logic [1:0] sampling_clock_delay,
    output logic [15:0] full_scale_a
);

    ////////////////////////////////////////////////////////////////////////
    // address decode, shared by the write and the read path

    function automatic scc_pkg::scc_reg_t decode(input logic [14:0] addr);
        scc_pkg::scc_reg_t sel;
        sel = scc_pkg::SEL_NONE;
        case (addr)
            scc_pkg::OFS_CLOCK_CONTROL_ZERO: sel = scc_pkg::SEL_CTRL0;
            scc_pkg::OFS_CLOCK_CONTROL_ONE: sel = scc_pkg::SEL_CTRL1;
            scc_pkg::OFS_CLOCK_CONTROL_TWO: sel = scc_pkg::SEL_CTRL2;
            scc_pkg::OFS_SREF_POS_LO: sel = scc_pkg::SEL_POS0;
            scc_pkg::OFS_SREF_POS_MID: sel = scc_pkg::SEL_POS1;
            scc_pkg::OFS_SREF_POS_HI: sel = scc_pkg::SEL_POS2;
            scc_pkg::OFS_FULL_SCALE_A_LO: sel = scc_pkg::SEL_FS0;
            scc_pkg::OFS_FULL_SCALE_A_HI: sel = scc_pkg::SEL_FS1;
            default: sel = scc_pkg::SEL_NONE;
        endcase
        return sel;
    endfunction

    scc_pkg::scc_reg_t wr_sel;
    scc_pkg::scc_reg_t rd_sel;

    assign wr_sel = decode(reg_addr);
    assign rd_sel = decode(reg_addr);

    ////////////////////////////////////////////////////////////////////////
    // control registers

    logic [7:0] ctrl0_ff;
    logic [7:0] ctrl1_ff;
    logic [7:0] ctrl2_ff;
    logic [15:0] fs_a_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_ff <= scc_pkg::RST_CLOCK_CONTROL_ZERO; // R19
        end else if (reg_wr && wr_sel == scc_pkg::SEL_CTRL0) begin
            ctrl0_ff <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_ff <= scc_pkg::RST_CLOCK_CONTROL_ONE; // R19
        end else if (reg_wr && wr_sel == scc_pkg::SEL_CTRL1) begin
            ctrl1_ff <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl2_ff <= scc_pkg::RST_CLOCK_CONTROL_TWO; // R16
        end else if (reg_wr && wr_sel == scc_pkg::SEL_CTRL2) begin
            ctrl2_ff <= reg_wdata;
        end
    end

    // full-scale range, low byte then high byte
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fs_a_ff <= scc_pkg::RST_FULL_SCALE_A;
        end else if (reg_wr && wr_sel == scc_pkg::SEL_FS0) begin
            fs_a_ff[7:0] <= reg_wdata;
        end else if (reg_wr && wr_sel == scc_pkg::SEL_FS1) begin
            fs_a_ff[15:8] <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field extraction

    logic proc_en;
    logic recv_en;
    logic fine_steps;
    logic [3:0] delay_sel;
    logic ts_en;
    logic invert;

    assign proc_en = ctrl0_ff[scc_pkg::BIT_PROC_EN]; // R1
    assign recv_en = ctrl0_ff[scc_pkg::BIT_RECV_EN]; // R3
    assign fine_steps = ctrl0_ff[scc_pkg::BIT_FINE_STEPS]; // R4
    assign delay_sel = ctrl0_ff[scc_pkg::SEL_LSB +: scc_pkg::SEL_W]; // R6
    assign ts_en = ctrl1_ff[scc_pkg::BIT_TIMESTAMP];
    assign invert = ctrl1_ff[scc_pkg::BIT_INVERT];

    // configuration levels for the analog side
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sref_receiver_on <= 1'b0;
            devclock_dc_pecl_enable <= 1'b0;
            sref_dc_pecl_enable <= 1'b0;
            clock_feedback_high_gain <= scc_pkg::RST_CLOCK_CONTROL_TWO[scc_pkg::BIT_FB_GAIN];
            analog_supply_noise_suppress <= 1'b0;
            sampling_clock_delay <= scc_pkg::RST_CLOCK_CONTROL_TWO[scc_pkg::DEL_LSB +: scc_pkg::DEL_W];
            full_scale_a <= scc_pkg::RST_FULL_SCALE_A;
        end else begin
            sref_receiver_on <= recv_en; // R3
            devclock_dc_pecl_enable <= ctrl1_ff[scc_pkg::BIT_DEVCLK_PECL]; // R10
            sref_dc_pecl_enable <= ctrl1_ff[scc_pkg::BIT_SREF_PECL]; // R11
            clock_feedback_high_gain <= ctrl2_ff[scc_pkg::BIT_FB_GAIN]; // R13
            analog_supply_noise_suppress <= ctrl2_ff[scc_pkg::BIT_NOISE_SUPP]; // R14
            sampling_clock_delay <= ctrl2_ff[scc_pkg::DEL_LSB +: scc_pkg::DEL_W]; // R15
            full_scale_a <= fs_a_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sysref input path

    logic sref_sync;
    logic sref_level;
    logic [23:0] position;
    logic aligned;
    logic event_pulse;

    scc_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(sref_pin),
        .sync_out(sref_sync)
    );

    // receiver off reads as a quiet low line; inversion after the receiver
    assign sref_level = recv_en & (sref_sync ^ invert); // R3 R12

    // processor only meaningful with the receiver on
    scc_pos_detect u_pos (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sref_level(sref_level),
        .proc_en(proc_en & recv_en), // R1 R2
        .fine_steps(fine_steps),
        .delay_sel(delay_sel),
        .position(position),
        .aligned(aligned),
        .sref_event(event_pulse)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sref_event <= 1'b0;
        end else begin
            sref_event <= event_pulse; // R1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timestamp insertion on the sample lsb

    logic stamp_active;

    assign stamp_active = ts_en & sample_timestamp_enable
        & (decimation_factor == scc_pkg::DECIM_BYPASS); // R8 R9

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_out <= '0;
            sample_out_valid <= 1'b0;
        end else begin
            sample_out_valid <= sample_in_valid;
            if (sample_in_valid) begin
                sample_out <= stamp_active ? {sample_in[11:1], aligned} : sample_in; // R8
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path; position bytes are read-only

    logic [7:0] nxt_rdata;

    always_comb begin
        case (rd_sel)
            scc_pkg::SEL_CTRL0: nxt_rdata = ctrl0_ff;
            scc_pkg::SEL_CTRL1: nxt_rdata = ctrl1_ff;
            scc_pkg::SEL_CTRL2: nxt_rdata = ctrl2_ff;
            scc_pkg::SEL_POS0: nxt_rdata = position[7:0]; // R17 R21
            scc_pkg::SEL_POS1: nxt_rdata = position[15:8]; // R17
            scc_pkg::SEL_POS2: nxt_rdata = position[23:16]; // R17
            scc_pkg::SEL_FS0: nxt_rdata = fs_a_ff[7:0];
            scc_pkg::SEL_FS1: nxt_rdata = fs_a_ff[15:8];
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= nxt_rdata;
            end
        end
    end

endmodule

// >>> scc_regs_properties.sv
// concurrent checks on the ports of the clock-control register bank
// assumes one core clock domain with an active-low reset
`timescale 1ns/1ps
module scc_regs_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [14:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    input wire logic [5:0] decimation_factor,
    input wire logic [11:0] sample_in,
    input wire logic sample_in_valid,
    input wire logic [11:0] sample_out,
    input wire logic sample_out_valid,
    input wire logic sref_event,
    input wire logic sref_receiver_on,
    input wire logic devclock_dc_pecl_enable,
    input wire logic sref_dc_pecl_enable,
    input wire logic clock_feedback_high_gain,
    input wire logic [1:0] sampling_clock_delay
);
    logic [5:0] off_cnt_ff;
    wire logic wr0 = reg_wr && reg_addr == scc_pkg::OFS_CLOCK_CONTROL_ZERO;
    wire logic wr1 = reg_wr && reg_addr == scc_pkg::OFS_CLOCK_CONTROL_ONE;
    wire logic wr2 = reg_wr && reg_addr == scc_pkg::OFS_CLOCK_CONTROL_TWO;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    // cycles with the receiver off, saturating
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt_ff <= 6'h00;
        end else begin
            off_cnt_ff <= sref_receiver_on ? 6'h00 : off_cnt_ff + 6'(off_cnt_ff != 6'h3f);
        end
    end
    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    rx_enable_a: assert property (wr0 |-> ##2 sref_receiver_on == $past(reg_wdata[5], 2))
        else $error("receiver enable wrong");
    pecl_modes_a: assert property (wr1 |-> ##2
        {devclock_dc_pecl_enable, sref_dc_pecl_enable} == $past(reg_wdata[2:1], 2))
        else $error("pecl mode outputs wrong");
    clock_tuning_a: assert property (wr2 |-> ##2
        {clock_feedback_high_gain, sampling_clock_delay} == {$past(reg_wdata[4], 2), $past(reg_wdata[1:0], 2)})
        else $error("clock tuning outputs wrong");
    valid_follow_a: assert property (sample_out_valid == $past(sample_in_valid))
        else $error("sample valid not delayed by one");
    passthrough_a: assert property (sample_in_valid && decimation_factor != scc_pkg::DECIM_BYPASS
        |=> sample_out == $past(sample_in))
        else $error("sample altered while decimating");
    event_gated_a: assert property (off_cnt_ff == 6'h3f |-> !sref_event)
        else $error("event with receiver off");
    event_pulse_a: assert property (sref_event |=> !sref_event)
        else $error("event longer than one cycle");
endmodule
bind scc_regs scc_regs_properties props (.*);

// >>> scc_host.sv
// host model on the byte register port of the clock-control bank
// assumes strobes are taken at the rising edge and reads answer one cycle later
`timescale 1ns/1ps
module scc_host (
    input wire logic core_clk,
    output logic [14:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 15'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
        reg_addr = ~a;
    endtask
    // answer looked at in the one cycle it stands
    task automatic rd(input logic [14:0] a, output logic [7:0] d, output bit ok);
        int n;
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
            @(negedge core_clk);
        end
        ok = reg_rvalid === 1'b1;
        d = reg_rdata;
    endtask
endmodule

// >>> testbench.sv
// self-checking bench for the clock-control and sysref register bank
// assumes the host model stands in for the serial register port
`timescale 1ns/1ps
module testbench;
    localparam logic [14:0] ctl0 = scc_pkg::OFS_CLOCK_CONTROL_ZERO;
    localparam logic [14:0] ctl1 = scc_pkg::OFS_CLOCK_CONTROL_ONE;
    localparam logic [7:0] rst_tab [10] = '{8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha0};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sref_pin = 1'b0;
    logic sample_timestamp_enable = 1'b0;
    logic sample_in_valid = 1'b0;
    logic [5:0] decimation_factor = 6'h01;
    logic [11:0] sample_in = 12'h000;
    logic [14:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, reg_rvalid, sample_out_valid, sref_event, sref_receiver_on;
    logic devclock_dc_pecl_enable, sref_dc_pecl_enable, clock_feedback_high_gain, analog_supply_noise_suppress;
    logic [1:0] sampling_clock_delay;
    logic [11:0] sample_out;
    logic [15:0] full_scale_a;
    logic [7:0] sh [3];
    logic [23:0] pos;
    int mismatches = 0;
    int cmp_count = 0;
    int lat0, lat, i, k;
    bit ok;
    wire [6:0] outs = {sref_receiver_on, devclock_dc_pecl_enable, sref_dc_pecl_enable, clock_feedback_high_gain,
        analog_supply_noise_suppress, sampling_clock_delay};
    scc_regs dut (.*);
    scc_host host (.*);
    initial forever #25 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic rd_chk(input string what, input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] v;
        bit got;
        host.rd(a, v, got);
        check("answer", got, 1'b1);
        check(what, v, exp);
    endtask
    // settle the pin at the opposite level, then time the aligned event
    task automatic edge_lat(input logic lvl, output int n);
        sref_pin = ~lvl;
        repeat (40) @(negedge core_clk);
        sref_pin = lvl;
        for (n = 0; n < 80 && sref_event !== 1'b1; n++) begin
            @(negedge core_clk);
        end
        repeat (40) @(negedge core_clk);
    endtask
    function automatic logic [11:0] exp_sample(input logic stamp, input logic lvl, input logic [11:0] s);
        return stamp ? {s[11:1], lvl} : s;
    endfunction
    initial begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end
    initial begin
        void'($urandom(32'hd478));
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        check("reset outs", outs, 7'h09);
        check("reset full scale", full_scale_a, scc_pkg::RST_FULL_SCALE_A);
        // quiet port time as after a soft reset
        repeat (15) @(negedge core_clk);
        for (i = 0; i < 10; i++) begin
            rd_chk("reset value", 15'h0028 + 15'(i), rst_tab[i]);
        end
        sh = '{8'h00, 8'h00, 8'h11};
        for (i = 0; i < 24; i++) begin
            k = $urandom_range(2);
            d = 8'($urandom);
            d[6] = d[6] & (k != 0);
            host.wr(ctl0 + 15'(k), d);
            sh[k] = d;
            rd_chk("control", ctl0 + 15'(k), d);
            check("outs", outs, {sh[0][5], sh[1][2:1], sh[2][4], sh[2][2], sh[2][1:0]});
        end
        for (i = 0; i < 4; i++) begin
            host.wr(15'h0028 + 15'(i ? i + 3 : 0), 8'($urandom) | 8'h01);
            rd_chk("read only", 15'h0028 + 15'(i ? i + 3 : 0), 8'h00);
        end
        host.wr(scc_pkg::OFS_FULL_SCALE_A_HI, 8'h5c);
        rd_chk("full scale", scc_pkg::OFS_FULL_SCALE_A_HI, 8'h5c);
        check("full scale out", full_scale_a, 16'h5c00);
        host.wr(ctl1, 8'h00);
        host.wr(ctl0, 8'h40);
        edge_lat(1'b1, lat);
        check("no receiver", lat, 80);
        host.wr(ctl0, 8'h30);
        host.wr(ctl0, 8'h70);
        edge_lat(1'b1, lat0);
        check("latency", lat0 < 20, 1'b1);
        for (i = 0; i < 4; i++) begin
            sref_pin = i[0];
            repeat (12) @(negedge core_clk);
        end
        repeat (30) @(negedge core_clk);
        for (i = 0; i < 3; i++) begin
            host.rd(scc_pkg::OFS_SREF_POS_LO + 15'(i), d, ok);
            check("position answer", ok, 1'b1);
            pos[8 * i +: 8] = d;
        end
        check("position", {pos[23:14], pos[9:0]}, 20'hffc00);
        for (i = 0; i < 2; i++) begin
            host.wr(ctl0, 8'h75 + 8'(i * 10));
            edge_lat(1'b1, lat);
            check("fine delay", lat - lat0, 5 + i * 10);
        end
        host.wr(ctl0, 8'h60);
        edge_lat(1'b1, k);
        host.wr(ctl0, 8'h64);
        edge_lat(1'b1, lat);
        check("coarse delay", (lat - k) inside {[7:9]}, 1'b1);
        host.wr(ctl0, 8'h70);
        host.wr(ctl1, 8'h01);
        edge_lat(1'b0, lat);
        check("inverted", lat, lat0);
        host.wr(ctl1, 8'h08);
        for (i = 0; i < 60; i++) begin
            if (i % 30 == 0) begin
                sref_pin = (i == 0);
                repeat (40) @(negedge core_clk);
            end
            sample_in = 12'($urandom);
            sample_in_valid = 1'b1;
            sample_timestamp_enable = (i % 3 != 1);
            decimation_factor = (i % 3 == 2) ? 6'($urandom_range(63, 2)) : 6'h01;
            @(negedge core_clk);
            check("sample", {sample_out_valid, sample_out}, {1'b1, exp_sample(i % 3 == 0, i < 30, sample_in)});
        end
        sample_in_valid = 1'b0;
        stop_test();
    end
endmodule
